// File: rtl/drscu_pkg.sv
// Constants shared by the serial command unit of the dual resistor.
// Assumes a single 50 MHz clock; SPI pins are sampled by that clock.
package drscu_pkg;
	localparam int FRAME_BITS = 24;
	localparam logic [4:0] FRAME_COUNT = 5'h18;
	localparam int WIPER_BITS = 10;
	localparam int NV_WORDS = 16;
	localparam logic [9:0] WIPER_FULL = 10'h3ff;
	localparam logic [9:0] WIPER_RESET = 10'h000;
	localparam logic [15:0] NV_RESET = 16'h0000;
	localparam logic [4:0] COUNT_RESET = 5'h00;
	localparam logic [23:0] WORD_RESET = 24'h000000;
	// Frame field positions
	localparam int CMD_MSB = 23;
	localparam int ADDR_MSB = 19;
	localparam int DATA_MSB = 15;
	// Store slots: wipers first, then the spare words
	localparam logic [3:0] SLOT_WIPER_A = 4'h0;
	localparam logic [3:0] SLOT_WIPER_B = 4'h1;
	localparam logic [3:0] SLOT_USER_FIRST = 4'h2;
	localparam logic [3:0] SLOT_USER_LAST = 4'he;
	// Command nibbles
	localparam logic [3:0] CMD_NOP = 4'h0;
	localparam logic [3:0] CMD_RESTORE = 4'h1;
	localparam logic [3:0] CMD_STORE = 4'h2;
	localparam logic [3:0] CMD_USER_STORE = 4'h3;
	localparam logic [3:0] CMD_RESTORE_ALL = 4'h8;
	localparam logic [3:0] CMD_READ_STORE = 4'h9;
	localparam logic [3:0] CMD_READ_WIPER = 4'ha;
	localparam logic [3:0] CMD_SET_WIPER = 4'hb;
	localparam logic [3:0] CMD_SHIFT_LEFT = 4'hc;
	localparam logic [3:0] CMD_INCREMENT = 4'he;
	typedef enum logic [2:0] {
		ST_RESTORE = 3'b001,
		ST_IDLE = 3'b010,
		ST_ACTIVE = 3'b100
	} drscu_state_e;
endpackage : drscu_pkg

// File: rtl/drscu_frame_if.sv
// Carries whole frames between the shift engine and the command core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface drscu_frame_if;
	import drscu_pkg::*;
	logic frame_valid;
	logic [FRAME_BITS-1:0] frame;
	logic [FRAME_BITS-1:0] tx_word;
	modport shifter (output frame_valid, output frame, input tx_word);
	modport core (input frame_valid, input frame, output tx_word);
endinterface : drscu_frame_if

// File: rtl/drscu_shifter.sv
// SPI slave shift engine, modes 0/0 and 1/1, MSB first, 24-bit frames.
// Assumes sclk, cs_n and serial_in are synchronous to i_mclk and slow.
`timescale 1ns/1ps
module drscu_shifter
	import drscu_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_serial_in,
	output logic o_serial_out,
	output logic o_serial_out_oe,
	drscu_frame_if.shifter frame_port
);
	logic sclk_reg, sclk_next;
	logic cs_n_reg, cs_n_next;
	logic valid_reg, valid_next;
	logic [4:0] count_reg, count_next;
	logic [FRAME_BITS-1:0] rx_reg, rx_next;
	logic [FRAME_BITS-1:0] tx_reg, tx_next;
	logic rise, fall, cs_fall, cs_rise;

	always_comb
	begin
		sclk_next = i_sclk;
		cs_n_next = i_cs_n;
		rise = i_sclk & ~sclk_reg & ~i_cs_n;
		fall = ~i_sclk & sclk_reg & ~i_cs_n;
		cs_fall = ~i_cs_n & cs_n_reg;
		cs_rise = i_cs_n & ~cs_n_reg;
		rx_next = rx_reg;
		tx_next = tx_reg;
		count_next = count_reg;
		valid_next = cs_rise && (count_reg == FRAME_COUNT);
		if (cs_fall)
		begin
			// First bit must stand before the first sampling edge
			tx_next = frame_port.tx_word;
			count_next = COUNT_RESET;
		end
		else
		begin
			if (rise && count_reg < FRAME_COUNT)
			begin
				rx_next = {rx_reg[FRAME_BITS-2:0], i_serial_in};
				count_next = count_reg + 5'h01;
			end
			// No shift before the first sample: mode 1/1 leads with a falling edge
			if (fall && count_reg != COUNT_RESET)
				tx_next = {tx_reg[FRAME_BITS-2:0], 1'b0};
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
		begin
			sclk_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			valid_reg <= 1'b0;
			count_reg <= COUNT_RESET;
			rx_reg <= WORD_RESET;
			tx_reg <= WORD_RESET;
		end
		else
		begin
			sclk_reg <= sclk_next;
			cs_n_reg <= cs_n_next;
			valid_reg <= valid_next;
			count_reg <= count_next;
			rx_reg <= rx_next;
			tx_reg <= tx_next;
		end
	end

	// Short frames are dropped whole
	assign frame_port.frame_valid = valid_reg;
	assign frame_port.frame = rx_reg;
	assign o_serial_out = tx_reg[FRAME_BITS-1];
	assign o_serial_out_oe = ~cs_n_reg;
endmodule : drscu_shifter

// File: rtl/drscu_top.sv
// Serial command unit of a dual programmable resistor with backing store.
// Assumes SPI pins and the preset pin are synchronous to i_mclk.
`timescale 1ns/1ps
module drscu_top
	import drscu_pkg::*;
#(
	parameter logic [15:0] NV_INIT = NV_RESET
)
(
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_serial_in,
	input wire logic i_preset_restore_pin_n,
	output logic o_serial_out,
	output logic o_serial_out_oe,
	output logic [WIPER_BITS-1:0] o_wiper_a,
	output logic [WIPER_BITS-1:0] o_wiper_b,
	output logic o_logic_active
);
	drscu_frame_if frame_bus ();

	drscu_shifter u_shifter (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_sclk(i_sclk),
		.i_cs_n(i_cs_n),
		.i_serial_in(i_serial_in),
		.o_serial_out(o_serial_out),
		.o_serial_out_oe(o_serial_out_oe),
		.frame_port(frame_bus.shifter)
	);

	drscu_state_e state_reg, state_next;
	logic [WIPER_BITS-1:0] wiper_reg [2];
	logic [WIPER_BITS-1:0] wiper_next [2];
	logic [FRAME_BITS-1:0] tx_reg, tx_next;
	logic preset_reg, preset_next;
	logic [15:0] nonvolatile_store [NV_WORDS];
	logic [15:0] store_next [NV_WORDS];
	logic nv_we;
	logic [3:0] nv_addr;
	logic [15:0] nv_wdata;
	logic [3:0] cmd, addr;
	logic [15:0] data;
	logic ch;
	logic ch_ok;
	logic user_ok;
	logic preset_strobe;

	assign cmd = frame_bus.frame[CMD_MSB -: 4];
	assign addr = frame_bus.frame[ADDR_MSB -: 4];
	assign data = frame_bus.frame[DATA_MSB -: 16];
	assign ch = addr[0];
	// Only slots 0 and 1 hold wipers; wiper frames elsewhere are refused
	assign ch_ok = (addr == SLOT_WIPER_A) || (addr == SLOT_WIPER_B);
	// Slot 15 has no spare word behind it
	assign user_ok = (addr >= SLOT_USER_FIRST) && (addr <= SLOT_USER_LAST);
	assign preset_strobe = preset_reg & ~i_preset_restore_pin_n;

	always_comb
	begin
		state_next = state_reg;
		wiper_next = wiper_reg;
		tx_next = tx_reg;
		preset_next = i_preset_restore_pin_n;
		nv_we = 1'b0;
		nv_addr = SLOT_WIPER_A;
		nv_wdata = NV_RESET;
		case (state_reg)
			ST_RESTORE:
			begin
				// Power-on reload of both channels
				wiper_next[0] = nonvolatile_store[SLOT_WIPER_A][WIPER_BITS-1:0];
				wiper_next[1] = nonvolatile_store[SLOT_WIPER_B][WIPER_BITS-1:0];
				state_next = ST_IDLE;
			end
			default:
			begin
				if (preset_strobe)
				begin
					wiper_next[0] = nonvolatile_store[SLOT_WIPER_A][WIPER_BITS-1:0];
					wiper_next[1] = nonvolatile_store[SLOT_WIPER_B][WIPER_BITS-1:0];
				end
				// A frame in the same cycle overrides the preset for its own channel
				if (frame_bus.frame_valid)
				begin
					tx_next = frame_bus.frame;
					case (cmd)
						CMD_NOP:
							state_next = ST_IDLE;
						CMD_RESTORE:
							if (ch_ok)
							begin
								wiper_next[ch] = nonvolatile_store[addr][WIPER_BITS-1:0];
								state_next = ST_ACTIVE;
							end
						CMD_STORE:
							if (ch_ok)
							begin
								nv_we = 1'b1;
								nv_addr = addr;
								nv_wdata = {6'h00, wiper_reg[ch]};
							end
						CMD_USER_STORE:
							if (user_ok)
							begin
								nv_we = 1'b1;
								nv_addr = addr;
								nv_wdata = data;
							end
						CMD_RESTORE_ALL:
						begin
							wiper_next[0] = nonvolatile_store[SLOT_WIPER_A][WIPER_BITS-1:0];
							wiper_next[1] = nonvolatile_store[SLOT_WIPER_B][WIPER_BITS-1:0];
							state_next = ST_ACTIVE;
						end
						CMD_READ_STORE:
						begin
							// Wiper slots read back too; they hold 10 bits
							tx_next = {cmd, addr, nonvolatile_store[addr]};
							state_next = ST_ACTIVE;
						end
						CMD_READ_WIPER:
							if (ch_ok)
							begin
								tx_next = {cmd, addr, 6'h00, wiper_reg[ch]};
								state_next = ST_ACTIVE;
							end
						CMD_SET_WIPER:
							if (ch_ok)
								wiper_next[ch] = data[WIPER_BITS-1:0];
						CMD_SHIFT_LEFT:
							if (ch_ok)
							begin
								// Top bit set means doubling overflows
								if (wiper_reg[ch][WIPER_BITS-1])
									wiper_next[ch] = WIPER_FULL;
								else
									wiper_next[ch] = {wiper_reg[ch][WIPER_BITS-2:0], 1'b0};
							end
						CMD_INCREMENT:
							if (ch_ok)
							begin
								// Held at full scale rather than wrapping to zero
								if (wiper_reg[ch] != WIPER_FULL)
									wiper_next[ch] = wiper_reg[ch] + 10'h001;
							end
						default:
							tx_next = frame_bus.frame;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
		begin
			state_reg <= ST_RESTORE;
			wiper_reg[0] <= WIPER_RESET;
			wiper_reg[1] <= WIPER_RESET;
			tx_reg <= WORD_RESET;
			preset_reg <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			wiper_reg <= wiper_next;
			tx_reg <= tx_next;
			preset_reg <= preset_next;
		end
	end

	// Store write port; at most one slot per frame
	always_comb
	begin
		store_next = nonvolatile_store;
		if (nv_we)
			store_next[nv_addr] = nv_wdata;
	end

	// Reset stands in for first power-up of an erased store
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
		begin
			for (int i = 0; i < NV_WORDS; i++)
				nonvolatile_store[i] <= NV_INIT;
		end
		else
			nonvolatile_store <= store_next;
	end

	assign frame_bus.tx_word = tx_reg;
	assign o_wiper_a = wiper_reg[0];
	assign o_wiper_b = wiper_reg[1];
	// High-power flag; only a no-operation frame or reset clears it
	assign o_logic_active = (state_reg == ST_ACTIVE);
endmodule : drscu_top

// File: bench/drscu_props.sv
// Pin-level checks on the serial command unit.
// Assumes every pin is sampled on the rising edge of i_mclk.
`timescale 1ns/1ps
module drscu_props
	import drscu_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_preset_restore_pin_n,
	input wire logic o_serial_out,
	input wire logic o_serial_out_oe,
	input wire logic [WIPER_BITS-1:0] o_wiper_a,
	input wire logic [WIPER_BITS-1:0] o_wiper_b,
	input wire logic o_logic_active
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_reset_n);
	oe_rise_a: assert property ($fell(i_cs_n) |-> ##[1:2] o_serial_out_oe)
		else $error("output enable late after select");
	oe_on_a: assert property ((!i_cs_n)[*3] |-> o_serial_out_oe)
		else $error("output enable low inside a frame");
	oe_off_a: assert property (i_cs_n[*3] |-> !o_serial_out_oe)
		else $error("output enable high outside a frame");
	out_steady_a: assert property ((i_sclk && !i_cs_n)[*4] |-> $stable(o_serial_out))
		else $error("serial output moved without a shift edge");
	wiper_a_quiet_a: assert property ((i_preset_restore_pin_n && $stable(i_cs_n))[*5]
		|-> $stable(o_wiper_a))
		else $error("wiper a moved with no frame or preset");
	wiper_b_quiet_a: assert property ((i_preset_restore_pin_n && $stable(i_cs_n))[*5]
		|-> $stable(o_wiper_b))
		else $error("wiper b moved with no frame or preset");
	active_edge_a: assert property ($changed(o_logic_active) |-> i_cs_n && $past(i_cs_n))
		else $error("active flag moved inside a frame");
	reset_clear_a: assert property (disable iff (1'b0) !i_reset_n |=> o_wiper_a == WIPER_RESET
		&& o_wiper_b == WIPER_RESET && !o_serial_out_oe && !o_serial_out && !o_logic_active)
		else $error("outputs not cleared by reset");
	cover property ($rose(o_logic_active));
	cover property ($fell(i_preset_restore_pin_n));
	cover property ($changed(o_wiper_b));
endmodule : drscu_props

bind drscu_top drscu_props props (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_sclk(i_sclk),
	.i_cs_n(i_cs_n), .i_preset_restore_pin_n(i_preset_restore_pin_n),
	.o_serial_out(o_serial_out), .o_serial_out_oe(o_serial_out_oe), .o_wiper_a(o_wiper_a),
	.o_wiper_b(o_wiper_b), .o_logic_active(o_logic_active));

// File: bench/drscu_host.sv
// SPI host model for the command unit: modes 0/0 and 1/1, MSB first.
// Assumes the bench clock; each sclk phase lasts four clocks.
`timescale 1ns/1ps
module drscu_host
(
	input wire logic i_mclk,
	input wire logic i_serial_out,
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_serial_in
);
	initial
	begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_serial_in = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : wait_clk
	// Short bit counts give frames the unit must drop
	task automatic xfer(input logic mode, input int bits, input logic [23:0] tx,
		output logic [23:0] rx);
		rx = 24'h000000;
		wait_clk(1);
		o_sclk = mode;
		wait_clk(4);
		o_cs_n = 1'b0;
		for (int i = 0; i < bits; i++)
		begin
			wait_clk(4);
			o_sclk = 1'b0;
			o_serial_in = tx[23-i];
			wait_clk(4);
			rx = {rx[22:0], i_serial_out};
			o_sclk = 1'b1;
		end
		wait_clk(4);
		o_sclk = mode;
		wait_clk(4);
		o_cs_n = 1'b1;
		// Released line must not keep its last bit
		o_serial_in = ~o_serial_in;
		wait_clk(8);
	endtask : xfer
endmodule : drscu_host

// File: bench/dual_resistor_serial_command_unit_bench.sv
// Self-checking bench for the serial command unit.
// Assumes the host model drives the SPI pins; the bench drives reset and preset.
`timescale 1ns/1ps
module dual_resistor_serial_command_unit_bench;
	import drscu_pkg::*;
	localparam logic [15:0] NV_SEED = 16'h0155;
	typedef struct packed {
		logic [23:0] tx;
		logic [23:0] rx;
		logic [9:0] wa;
		logic [9:0] wb;
		logic act;
	} drscu_row_s;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic preset_n = 1'b1;
	logic sclk, cs_n, serial_in, serial_out, serial_out_oe, logic_active;
	logic [9:0] wiper_a, wiper_b;
	logic [23:0] rx;
	int fail_count = 0;
	int checks = 0;
	int cycles = 0;
	// Mode alternates per row; NOPs follow every read and restore
	drscu_row_s rows [30] = '{
		'{24'hb00100, 24'h000000, 10'h100, 10'h155, 1'b0},
		'{24'hb10200, 24'hb00100, 10'h100, 10'h200, 1'b0},
		'{24'he00000, 24'hb10200, 10'h101, 10'h200, 1'b0},
		'{24'he00000, 24'he00000, 10'h102, 10'h200, 1'b0},
		'{24'h200000, 24'he00000, 10'h102, 10'h200, 1'b0},
		'{24'hb003fe, 24'h200000, 10'h3fe, 10'h200, 1'b0},
		'{24'he00000, 24'hb003fe, 10'h3ff, 10'h200, 1'b0},
		'{24'he00000, 24'he00000, 10'h3ff, 10'h200, 1'b0},
		'{24'h100000, 24'he00000, 10'h102, 10'h200, 1'b1},
		'{24'h000000, 24'h100000, 10'h102, 10'h200, 1'b0},
		'{24'hc10000, 24'h000000, 10'h102, 10'h3ff, 1'b0},
		'{24'hb00101, 24'hc10000, 10'h101, 10'h3ff, 1'b0},
		'{24'hc00000, 24'hb00101, 10'h202, 10'h3ff, 1'b0},
		'{24'h32aaaa, 24'hc00000, 10'h202, 10'h3ff, 1'b0},
		'{24'h335555, 24'h32aaaa, 10'h202, 10'h3ff, 1'b0},
		'{24'h920000, 24'h335555, 10'h202, 10'h3ff, 1'b1},
		'{24'h000000, 24'h92aaaa, 10'h202, 10'h3ff, 1'b0},
		'{24'h930000, 24'h000000, 10'h202, 10'h3ff, 1'b1},
		'{24'h000000, 24'h935555, 10'h202, 10'h3ff, 1'b0},
		'{24'ha00000, 24'h000000, 10'h202, 10'h3ff, 1'b1},
		'{24'h000000, 24'ha00202, 10'h202, 10'h3ff, 1'b0},
		'{24'ha10000, 24'h000000, 10'h202, 10'h3ff, 1'b1},
		'{24'h000000, 24'ha103ff, 10'h202, 10'h3ff, 1'b0},
		'{24'h301234, 24'h000000, 10'h202, 10'h3ff, 1'b0},
		'{24'hb20123, 24'h301234, 10'h202, 10'h3ff, 1'b0},
		'{24'h412345, 24'hb20123, 10'h202, 10'h3ff, 1'b0},
		'{24'h910000, 24'h412345, 10'h202, 10'h3ff, 1'b1},
		'{24'h000000, 24'h910155, 10'h202, 10'h3ff, 1'b0},
		'{24'h800000, 24'h000000, 10'h102, 10'h155, 1'b1},
		'{24'h000000, 24'h800000, 10'h102, 10'h155, 1'b0}};

	always #10 mclk = ~mclk;

	drscu_top #(.NV_INIT(NV_SEED)) uut (.i_mclk(mclk), .i_reset_n(reset_n), .i_sclk(sclk),
		.i_cs_n(cs_n), .i_serial_in(serial_in), .i_preset_restore_pin_n(preset_n),
		.o_serial_out(serial_out), .o_serial_out_oe(serial_out_oe), .o_wiper_a(wiper_a),
		.o_wiper_b(wiper_b), .o_logic_active(logic_active));
	drscu_host host (.i_mclk(mclk), .i_serial_out(serial_out), .o_sclk(sclk), .o_cs_n(cs_n),
		.o_serial_in(serial_in));

	task automatic report_and_stop;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH %0t output word %h expected %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_state(input logic [9:0] a, input logic [9:0] b, input logic act);
		checks++;
		if ({wiper_a, wiper_b, logic_active} !== {a, b, act})
		begin
			fail_count++;
			$display("MISMATCH %0t wipers %h %h active %b", $time, wiper_a, wiper_b, logic_active);
		end
	endtask : chk_state

	// Ceiling well above the roughly 7000 clocks the tests take
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			report_and_stop();
		end
	end

	initial
	begin
		host.wait_clk(5);
		reset_n = 1'b1;
		host.wait_clk(4);
		chk_state(NV_SEED[9:0], NV_SEED[9:0], 1'b0);
		foreach (rows[i])
		begin
			host.xfer(i[0], 24, rows[i].tx, rx);
			chk_word(rx, rows[i].rx);
			chk_state(rows[i].wa, rows[i].wb, rows[i].act);
		end
		host.xfer(1'b0, 12, 24'hb00333, rx);
		chk_state(10'h102, 10'h155, 1'b0);
		host.xfer(1'b1, 24, 24'hb00333, rx);
		chk_state(10'h333, 10'h155, 1'b0);
		preset_n = 1'b0;
		host.wait_clk(4);
		preset_n = 1'b1;
		host.wait_clk(2);
		chk_state(10'h102, 10'h155, 1'b0);
		reset_n = 1'b0;
		host.wait_clk(5);
		reset_n = 1'b1;
		host.wait_clk(4);
		chk_state(NV_SEED[9:0], NV_SEED[9:0], 1'b0);
		report_and_stop();
	end
endmodule : dual_resistor_serial_command_unit_bench
